//--- hw/vpsg_cfg.svh
/*
 * Constants of the wide-vector permute, shift and gather datapath.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef VPSG_CFG_SVH
`define VPSG_CFG_SVH
`define VPSG_VLEN 256
`define VPSG_HLEN 128
`define VPSG_NREG 16
`define VPSG_RIDX_W 4
`define VPSG_DW 32
`define VPSG_QW 64
`define VPSG_ND 8
`define VPSG_NQ 4
`define VPSG_ADDR_W 64
`define VPSG_FEAT_BIT 5
`define VPSG_FEAT_LEAF 32'h0000_0007
`define VPSG_FEAT_SUB 32'h0000_0000
`endif

//--- hw/vpsg_pkg.sv
/*
 * Types of the wide-vector permute, shift and gather datapath.
 * Assumes vpsg_cfg.svh is on the include path.
 */
`include "vpsg_cfg.svh"
package vpsg_pkg;
    typedef enum logic [4:0] {
        VPSG_OP_NOP = 5'h00,
        VPSG_OP_PERM_D = 5'h01,
        VPSG_OP_PERM_PD = 5'h02,
        VPSG_OP_PERM_PS = 5'h03,
        VPSG_OP_PERM_Q = 5'h04,
        VPSG_OP_SLLV_D = 5'h05,
        VPSG_OP_SLLV_Q = 5'h06,
        VPSG_OP_SRAV_D = 5'h07,
        VPSG_OP_SRLV_D = 5'h08,
        VPSG_OP_SRLV_Q = 5'h09,
        VPSG_OP_GATHER = 5'h0a,
        VPSG_OP_LEG_MOV = 5'h0b,
        VPSG_OP_PFX_MOV = 5'h0c,
        VPSG_OP_SAVE_HI = 5'h0d,
        VPSG_OP_REST_HI = 5'h0e
    } vpsg_op_t;
    typedef enum logic [1:0] {
        VPSG_ET_D = 2'h0,
        VPSG_ET_Q = 2'h1,
        VPSG_ET_S = 2'h2,
        VPSG_ET_PD = 2'h3
    } vpsg_etype_t;
    typedef enum logic [1:0] {
        VPSG_ST_IDLE = 2'h0,
        VPSG_ST_REQ = 2'h1,
        VPSG_ST_WAIT = 2'h3,
        VPSG_ST_DONE = 2'h2
    } vpsg_state_t;
    typedef struct packed {
        logic valid;
        vpsg_op_t op;
        logic wide;
        vpsg_etype_t etype;
        logic qidx;
        logic [`VPSG_RIDX_W-1:0] dst;
        logic [`VPSG_RIDX_W-1:0] src1;
        logic [`VPSG_RIDX_W-1:0] src2;
        logic [`VPSG_RIDX_W-1:0] src3;
        logic [7:0] imm;
        logic [`VPSG_ADDR_W-1:0] base;
        logic [1:0] scale_log2;
        logic [`VPSG_VLEN-1:0] ldata;
    } vpsg_cmd_t;
    typedef struct packed {
        logic req;
        logic [`VPSG_ADDR_W-1:0] addr;
        logic is_q;
    } vpsg_mreq_t;
    typedef struct packed {
        vpsg_state_t st;
        logic busy;
        logic done;
        logic [`VPSG_VLEN-1:0] res;
        logic [`VPSG_VLEN-1:0] acc;
        logic [`VPSG_VLEN-1:0] msk;
        logic [`VPSG_VLEN-1:0] idx;
        logic [2:0] el;
        vpsg_cmd_t cmd;
        vpsg_mreq_t mreq;
        logic [`VPSG_NREG-1:0][`VPSG_VLEN-1:0] regs;
    } vpsg_state_dummy_t;
endpackage : vpsg_pkg

//--- hw/vpsg_core.sv
/*
 * Permute, variable shift and masked gather datapath over a wide register file.
 * Assumes the issue logic holds cmd_i until ready_o and that memory
 * answers each single-element load with one rvalid pulse.
 */
// What this block does
// - Dword permute indexed by a vector register.
// - Double permute picks qwords by immediate fields.
// - Single permute indexed by a vector register.
// - Qword permute picks qwords by immediate fields.
// - Variable left shift, zero fill, both widths.
// - Variable arithmetic right shift fills sign bits.
// - Variable logical right shift, zero fill, both widths.
// - Dword gather index is signed, added to base.
// - Qword gather index allows at most four elements.
// - Masked-off gather elements make no memory access.
// - Masked-off destination elements keep old contents.
// - Gather handles four element types, all combinations.
// - Feature query leaf seven, subleaf zero, reports extension bit five.
// - Low half shares storage with narrow register.
// - Legacy operations preserve the upper half.
// - Narrow prefixed shifts, moves and gathers zero the upper half.
// - Wide prefixed operations reach the upper half.
// - Save and restore carry the upper halves.
`timescale 1ns/1ps
`default_nettype none
`include "vpsg_cfg.svh"
module vpsg_core (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Command from issue logic
    input wire vpsg_pkg::vpsg_cmd_t cmd_i,
    output logic ready_o,
    output logic done_o,
    // Data memory, one element per request
    output vpsg_pkg::vpsg_mreq_t mreq_o,
    input wire logic mem_rvalid_i,
    input wire logic [`VPSG_QW-1:0] mem_rdata_i,
    // Register read port and save path
    input wire logic [`VPSG_RIDX_W-1:0] rd_idx_i,
    output logic [`VPSG_VLEN-1:0] rd_data_o,
    // Feature identification query
    input wire logic [31:0] feat_leaf_i,
    input wire logic [31:0] feat_sub_i,
    output logic [31:0] feat_word_o
);
    typedef struct packed {
        vpsg_pkg::vpsg_state_t st;
        logic done;
        logic rdy;
        logic [`VPSG_VLEN-1:0] acc;
        logic [`VPSG_VLEN-1:0] msk;
        logic [`VPSG_VLEN-1:0] idx;
        logic [2:0] el;
        vpsg_pkg::vpsg_cmd_t cmd;
        vpsg_pkg::vpsg_mreq_t mreq;
        logic [`VPSG_VLEN-1:0] rd;
        logic [31:0] feat;
        logic [`VPSG_NREG-1:0][`VPSG_VLEN-1:0] regs;
    } vpsg_core_st_t;

    vpsg_core_st_t s_r;
    vpsg_core_st_t s_nxt;

    // ----------------------------------------------------------------
    // Element helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] sh_d(input logic [31:0] v, input logic [31:0] c,
                                         input logic [1:0] kind);
        logic big;
        big = (c >= 32'(`VPSG_DW));
        case (kind)
            2'h0: sh_d = big ? 32'h0 : v << c[4:0];
            2'h1: sh_d = big ? 32'h0 : v >> c[4:0];
            default: sh_d = big ? {32{v[31]}} : 32'($signed(v) >>> c[4:0]);
        endcase
    endfunction : sh_d

    function automatic logic [63:0] sh_q(input logic [63:0] v, input logic [63:0] c,
                                         input logic left);
        logic big;
        big = (c >= 64'(`VPSG_QW));
        if (big) begin
            sh_q = 64'h0;
        end else if (left) begin
            sh_q = v << c[5:0];
        end else begin
            sh_q = v >> c[5:0];
        end
    endfunction : sh_q

    function automatic logic [`VPSG_VLEN-1:0] narrow_fix(input logic [`VPSG_VLEN-1:0] v,
                                                         input logic wide);
        narrow_fix = wide ? v : {{`VPSG_HLEN{1'b0}}, v[`VPSG_HLEN-1:0]};
    endfunction : narrow_fix

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [`VPSG_VLEN-1:0] a;
        logic [`VPSG_VLEN-1:0] b;
        logic [`VPSG_VLEN-1:0] r;
        logic [`VPSG_ADDR_W-1:0] ofs;
        logic [2:0] nel;
        logic isq;
        logic found;
        logic [2:0] pick;
        a = '0;
        b = '0;
        r = '0;
        ofs = '0;
        nel = '0;
        isq = 1'b0;
        found = 1'b0;
        pick = '0;
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.mreq.req = 1'b0;
        s_nxt.rd = s_r.regs[rd_idx_i];
        s_nxt.feat = '0;
        if (feat_leaf_i == `VPSG_FEAT_LEAF && feat_sub_i == `VPSG_FEAT_SUB) begin
            s_nxt.feat[`VPSG_FEAT_BIT] = 1'b1;
        end
        case (s_r.st)
            vpsg_pkg::VPSG_ST_IDLE: begin
                if (cmd_i.valid) begin
                    a = s_r.regs[cmd_i.src1];
                    b = s_r.regs[cmd_i.src2];
                    r = s_r.regs[cmd_i.dst];
                    s_nxt.cmd = cmd_i;
                    s_nxt.st = vpsg_pkg::VPSG_ST_DONE;
                    case (cmd_i.op)
                        vpsg_pkg::VPSG_OP_PERM_D, vpsg_pkg::VPSG_OP_PERM_PS: begin
                            for (int i = 0; i < `VPSG_ND; i++) begin
                                r[i*32 +: 32] = b[a[i*32 +: 3]*32 +: 32];
                            end
                        end
                        vpsg_pkg::VPSG_OP_PERM_PD, vpsg_pkg::VPSG_OP_PERM_Q: begin
                            for (int i = 0; i < `VPSG_NQ; i++) begin
                                r[i*64 +: 64] = a[cmd_i.imm[i*2 +: 2]*64 +: 64];
                            end
                        end
                        vpsg_pkg::VPSG_OP_SLLV_D, vpsg_pkg::VPSG_OP_SRLV_D,
                        vpsg_pkg::VPSG_OP_SRAV_D: begin
                            for (int i = 0; i < `VPSG_ND; i++) begin
                                r[i*32 +: 32] = sh_d(a[i*32 +: 32], b[i*32 +: 32],
                                    cmd_i.op == vpsg_pkg::VPSG_OP_SLLV_D ? 2'h0 :
                                    cmd_i.op == vpsg_pkg::VPSG_OP_SRLV_D ? 2'h1 : 2'h2);
                            end
                            r = narrow_fix(r, cmd_i.wide);
                        end
                        vpsg_pkg::VPSG_OP_SLLV_Q, vpsg_pkg::VPSG_OP_SRLV_Q: begin
                            for (int i = 0; i < `VPSG_NQ; i++) begin
                                r[i*64 +: 64] = sh_q(a[i*64 +: 64], b[i*64 +: 64],
                                    cmd_i.op == vpsg_pkg::VPSG_OP_SLLV_Q);
                            end
                            r = narrow_fix(r, cmd_i.wide);
                        end
                        vpsg_pkg::VPSG_OP_GATHER: begin
                            s_nxt.acc = r;
                            s_nxt.idx = a;
                            s_nxt.msk = b;
                            s_nxt.el = '0;
                            s_nxt.st = vpsg_pkg::VPSG_ST_REQ;
                        end
                        vpsg_pkg::VPSG_OP_LEG_MOV: begin
                            r[`VPSG_HLEN-1:0] = a[`VPSG_HLEN-1:0];
                        end
                        vpsg_pkg::VPSG_OP_PFX_MOV: begin
                            r = narrow_fix(a, cmd_i.wide);
                        end
                        vpsg_pkg::VPSG_OP_REST_HI: begin
                            r[`VPSG_VLEN-1:`VPSG_HLEN] = cmd_i.ldata[`VPSG_VLEN-1:`VPSG_HLEN];
                        end
                        default: begin
                            r = s_r.regs[cmd_i.dst];
                        end
                    endcase
                    if (cmd_i.op != vpsg_pkg::VPSG_OP_GATHER) begin
                        s_nxt.regs[cmd_i.dst] = r;
                    end
                end
            end
            vpsg_pkg::VPSG_ST_REQ: begin
                isq = s_r.cmd.etype == vpsg_pkg::VPSG_ET_Q || s_r.cmd.etype == vpsg_pkg::VPSG_ET_PD;
                // Element count: data width and index width each limit it.
                nel = (isq || s_r.cmd.qidx) ? 3'(`VPSG_NQ - 1) : 3'(`VPSG_ND - 1);
                if (!s_r.cmd.wide) begin
                    nel = {1'b0, nel[2:1]};
                end
                found = 1'b0;
                pick = s_r.el;
                for (int k = 7; k >= 0; k--) begin
                    if (3'(k) >= s_r.el && 3'(k) <= nel &&
                        (isq ? s_r.msk[(k%4)*64+63] : s_r.msk[k*32+31])) begin
                        found = 1'b1;
                        pick = 3'(k);
                    end
                end
                if (!found) begin
                    s_nxt.regs[s_r.cmd.dst] = narrow_fix(s_r.acc, s_r.cmd.wide);
                    s_nxt.st = vpsg_pkg::VPSG_ST_DONE;
                end else begin
                    if (s_r.cmd.qidx) begin
                        ofs = s_r.idx[pick*64 +: 64];
                    end else begin
                        ofs = 64'($signed(s_r.idx[pick*32 +: 32]));
                    end
                    s_nxt.mreq.req = 1'b1;
                    s_nxt.mreq.addr = s_r.cmd.base + (ofs << s_r.cmd.scale_log2);
                    s_nxt.mreq.is_q = isq;
                    s_nxt.el = pick;
                    s_nxt.st = vpsg_pkg::VPSG_ST_WAIT;
                end
            end
            vpsg_pkg::VPSG_ST_WAIT: begin
                if (mem_rvalid_i) begin
                    if (s_r.mreq.is_q) begin
                        s_nxt.acc[s_r.el*64 +: 64] = mem_rdata_i;
                    end else begin
                        s_nxt.acc[s_r.el*32 +: 32] = mem_rdata_i[31:0];
                    end
                    if (s_r.el == 3'h7) begin
                        s_nxt.regs[s_r.cmd.dst] = narrow_fix(s_nxt.acc, s_r.cmd.wide);
                        s_nxt.st = vpsg_pkg::VPSG_ST_DONE;
                    end else begin
                        s_nxt.el = s_r.el + 3'h1;
                        s_nxt.st = vpsg_pkg::VPSG_ST_REQ;
                    end
                end
            end
            vpsg_pkg::VPSG_ST_DONE: begin
                s_nxt.done = 1'b1;
                s_nxt.st = vpsg_pkg::VPSG_ST_IDLE;
            end
            default: begin
                s_nxt.st = vpsg_pkg::VPSG_ST_IDLE;
            end
        endcase
        // Ready is a flop so that the issue side never sees a decode glitch.
        s_nxt.rdy = (s_nxt.st == vpsg_pkg::VPSG_ST_IDLE);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '0;
            s_r.rdy <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ready_o = s_r.rdy;
    assign done_o = s_r.done;
    assign mreq_o = s_r.mreq;
    assign rd_data_o = s_r.rd;
    assign feat_word_o = s_r.feat;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_req_issued;
        s_r.mreq.req;
    endsequence

    sequence s_done_ready;
        done_o && ready_o;
    endsequence

    property p_feat_bit;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (feat_leaf_i == `VPSG_FEAT_LEAF && feat_sub_i == `VPSG_FEAT_SUB)
        |=> feat_word_o[`VPSG_FEAT_BIT];
    endproperty
    a_feat_bit: assert property (p_feat_bit) else $error("feature bit missing");

    property p_req_masked;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        s_req_issued |-> (s_r.mreq.is_q ? s_r.msk[s_r.el*64+63] : s_r.msk[s_r.el*32+31]);
    endproperty
    a_req_masked: assert property (p_req_masked) else $error("disabled element loaded");

    property p_req_wait;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        s_req_issued |-> s_r.st == vpsg_pkg::VPSG_ST_WAIT;
    endproperty
    a_req_wait: assert property (p_req_wait) else $error("request outside wait");

    property p_qidx_four;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (s_r.mreq.req && s_r.cmd.qidx) |-> s_r.el < 3'(`VPSG_NQ);
    endproperty
    a_qidx_four: assert property (p_qidx_four) else $error("qword index past fourth element");

    property p_sll_d;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (ready_o && cmd_i.valid && cmd_i.op == vpsg_pkg::VPSG_OP_SLLV_D && cmd_i.dst != cmd_i.src1
         && cmd_i.dst != cmd_i.src2)
        |=> s_r.regs[$past(cmd_i.dst)][31:0]
            == sh_d($past(s_r.regs[cmd_i.src1][31:0]), $past(s_r.regs[cmd_i.src2][31:0]), 2'h0);
    endproperty
    a_sll_d: assert property (p_sll_d) else $error("left shift wrong");

    property p_sra_big;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (ready_o && cmd_i.valid && cmd_i.op == vpsg_pkg::VPSG_OP_SRAV_D
         && s_r.regs[cmd_i.src2][31:0] >= 32'd32)
        |=> s_r.regs[$past(cmd_i.dst)][31:0] == {32{$past(s_r.regs[cmd_i.src1][31])}};
    endproperty
    a_sra_big: assert property (p_sra_big) else $error("sign fill wrong");

    property p_narrow_zero;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (ready_o && cmd_i.valid && !cmd_i.wide && cmd_i.op == vpsg_pkg::VPSG_OP_PFX_MOV)
        |=> s_r.regs[$past(cmd_i.dst)][255:128] == '0;
    endproperty
    a_narrow_zero: assert property (p_narrow_zero) else $error("upper half kept");

    property p_legacy_keep;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (ready_o && cmd_i.valid && cmd_i.op == vpsg_pkg::VPSG_OP_LEG_MOV)
        |=> s_r.regs[$past(cmd_i.dst)][255:128] == $past(s_r.regs[cmd_i.dst][255:128]);
    endproperty
    a_legacy_keep: assert property (p_legacy_keep) else $error("upper half changed");

    property p_permq;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (ready_o && cmd_i.valid && cmd_i.op == vpsg_pkg::VPSG_OP_PERM_Q && cmd_i.dst != cmd_i.src1)
        |=> s_r.regs[$past(cmd_i.dst)][63:0]
            == $past(s_r.regs[cmd_i.src1][cmd_i.imm[1:0]*64 +: 64]);
    endproperty
    a_permq: assert property (p_permq) else $error("qword permute wrong");

    property p_done_after;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (s_r.st == vpsg_pkg::VPSG_ST_DONE) |=> s_done_ready;
    endproperty
    a_done_after: assert property (p_done_after) else $error("done pulse missing");
endmodule : vpsg_core
`default_nettype wire

//--- verification/vpsg_mem_model.sv
/*
 * Data memory model that answers the datapath's single-element loads.
 * Assumes one load outstanding at a time; lat_i sets the answer delay.
 */
`timescale 1ns/1ps
`default_nettype none
module vpsg_mem_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Load request and answer
    input wire vpsg_pkg::vpsg_mreq_t mreq_i,
    input wire logic [7:0] lat_i,
    output logic rvalid_o,
    output logic [63:0] rdata_o,
    output logic [31:0] req_cnt_o
);
    logic pend_r;
    logic [7:0] wait_r;
    logic [63:0] addr_r;
    // Data toggles between answers so that stale data is never taken for an answer.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend_r <= 1'b0;
            wait_r <= 8'h00;
            addr_r <= 64'h0;
            rvalid_o <= 1'b0;
            rdata_o <= 64'h0;
            req_cnt_o <= 32'h0;
        end else begin
            rvalid_o <= 1'b0;
            rdata_o <= ~rdata_o;
            if (mreq_i.req) begin
                pend_r <= 1'b1;
                wait_r <= lat_i;
                addr_r <= mreq_i.addr;
                req_cnt_o <= req_cnt_o + 32'h1;
            end else if (pend_r && wait_r != 8'h00) begin
                wait_r <= wait_r - 8'h01;
            end else if (pend_r) begin
                pend_r <= 1'b0;
                rvalid_o <= 1'b1;
                rdata_o <= {addr_r[31:0] ^ 32'ha5a5_0f0f, addr_r[31:0] + 32'h1234_0001};
            end
        end
    end
endmodule : vpsg_mem_model
`default_nettype wire

//--- verification/tb_top.sv
/*
 * Self-checking bench of the vector permute, shift and gather datapath.
 * Assumes vpsg_pkg and the memory model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    vpsg_pkg::vpsg_cmd_t cmd_i = '0;
    vpsg_pkg::vpsg_mreq_t mreq_o;
    logic ready_o, done_o, mem_rvalid_i, chk_v = 1'b0, chk_f = 1'b0;
    logic [63:0] mem_rdata_i;
    logic [3:0] rd_idx_i = 4'h0;
    logic [7:0] lat = 8'h00;
    logic [31:0] feat_leaf_i = 32'h0, feat_sub_i = 32'h0, feat_word_o, req_cnt, exp_f [$];
    logic [255:0] rd_data_o, rf [16], exp_v [$];
    int err_total = 0;
    int checks = 0;
    always #5 core_clk_i = ~core_clk_i;
    vpsg_core u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cmd_i(cmd_i),
        .ready_o(ready_o), .done_o(done_o), .mreq_o(mreq_o), .mem_rvalid_i(mem_rvalid_i),
        .mem_rdata_i(mem_rdata_i), .rd_idx_i(rd_idx_i), .rd_data_o(rd_data_o),
        .feat_leaf_i(feat_leaf_i), .feat_sub_i(feat_sub_i), .feat_word_o(feat_word_o));
    vpsg_mem_model u_mem (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .mreq_i(mreq_o),
        .lat_i(lat), .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i), .req_cnt_o(req_cnt));
    // ----------------------------------------
    // Compare, report and reference models
    // ----------------------------------------
    task automatic cmp_vec(input string what, input logic [255:0] e, input logic [255:0] s);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask : cmp_vec
    task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask : cmp_word
    task automatic wrap_up();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    function automatic logic [63:0] mdat(input logic [63:0] a);
        mdat = {a[31:0] ^ 32'ha5a5_0f0f, a[31:0] + 32'h1234_0001};
    endfunction : mdat
    function automatic logic [255:0] rnd();
        for (int i = 0; i < 8; i++) rnd[32*i +: 32] = $urandom;
    endfunction : rnd
    function automatic vpsg_pkg::vpsg_cmd_t mk(input logic [4:0] op, input logic w,
            input logic [3:0] d, input logic [3:0] s1, input logic [3:0] s2);
        mk = '0;
        mk.op = vpsg_pkg::vpsg_op_t'(op);
        mk.wide = w;
        mk.dst = d;
        mk.src1 = s1;
        mk.src2 = s2;
    endfunction : mk
    // Counts at or above the element width are kept on purpose: they are the corner case.
    function automatic logic [255:0] shf(input logic [4:0] op, input logic w,
            input logic [255:0] v, input logic [255:0] k);
        int ew;
        logic [63:0] a, n, m, r;
        shf = '0;
        ew = (op == 5'h06 || op == 5'h09) ? 64 : 32;
        m = (ew == 64) ? '1 : 64'hffff_ffff;
        for (int i = 0; i < (w ? 256 : 128) / ew; i++) begin
            a = (v >> (ew * i)) & m;
            n = (k >> (ew * i)) & m;
            if (op == 5'h07) r = (n >= 32) ? {64{a[31]}} : {{32{a[31]}}, a[31:0]} >> n;
            else if (op == 5'h05 || op == 5'h06) r = (n >= ew) ? 64'h0 : a << n;
            else r = (n >= ew) ? 64'h0 : a >> n;
            shf = shf | (256'(r & m) << (ew * i));
        end
    endfunction : shf
    function automatic logic [255:0] gat(input logic [255:0] old, input logic [255:0] idx,
            input logic [255:0] msk, input logic [63:0] base, input logic [1:0] sc,
            input logic [1:0] et, input logic qx, input logic w, output int nq);
        int de, ne;
        logic [63:0] m, ad;
        gat = old;
        nq = 0;
        de = et[0] ? 64 : 32;
        m = et[0] ? '1 : 64'hffff_ffff;
        ne = (qx || et[0]) ? 4 : 8;
        if (!w) ne = ne / 2;
        for (int i = 0; i < ne; i++) begin
            if (msk[de * i + de - 1]) begin
                ad = base + ((qx ? idx[64*i +: 64] : 64'($signed(idx[32*i +: 32]))) << sc);
                gat = (gat & ~(256'(m) << (de * i))) | (256'(mdat(ad) & m) << (de * i));
                nq++;
            end
        end
        if (!w) gat[255:128] = '0;
    endfunction : gat
    // ----------------------------------------
    // Drivers and result watcher
    // ----------------------------------------
    task automatic issue(input vpsg_pkg::vpsg_cmd_t c);
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 50) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        if (ready_o !== 1'b1) n = 250;
        c.valid = 1'b1;
        cmd_i = c;
        @(posedge core_clk_i);
        #1;
        cmd_i.valid = 1'b0;
        while (done_o !== 1'b1 && n < 250) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        if (n >= 250) begin
            err_total++;
            wrap_up();
        end
    endtask : issue
    task automatic show(input logic [3:0] r);
        rd_idx_i = r;
        exp_v.push_back(rf[r]);
        @(posedge core_clk_i);
        #1;
        chk_v = 1'b1;
        @(posedge core_clk_i);
        #1;
        chk_v = 1'b0;
    endtask : show
    // The low half is reachable only by permuting a restored upper half of a scratch register.
    task automatic load(input logic [3:0] r, input logic [255:0] v);
        vpsg_pkg::vpsg_cmd_t c;
        c = mk(5'h0e, 1'b1, 4'hf, 4'h0, 4'h0);
        c.ldata = {v[127:0], 128'h0};
        issue(c);
        c = mk(5'h04, 1'b1, r, 4'hf, 4'h0);
        c.imm = 8'hee;
        issue(c);
        c = mk(5'h0e, 1'b1, r, 4'h0, 4'h0);
        c.ldata = v;
        issue(c);
        rf[15][255:128] = v[127:0];
        rf[r] = v;
    endtask : load
    always @(posedge core_clk_i) begin
        if (chk_v) cmp_vec("rd_data_o", exp_v.pop_front(), rd_data_o);
        if (chk_f) cmp_word("feat_word_o", exp_f.pop_front(), feat_word_o);
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [255:0] a, b;
        logic [31:0] n0;
        logic [1:0] et;
        logic w, qx;
        int nq, x;
        vpsg_pkg::vpsg_cmd_t c;
        void'($urandom(32'h6c36));
        for (int r = 0; r < 16; r++) rf[r] = '0;
        repeat (20) @(posedge core_clk_i);
        #1;
        reset_n_i = 1'b1;
        // The query order follows the software detection sequence.
        for (int j = 0; j < 3; j++) begin
            feat_leaf_i = (j == 2) ? 32'h1 : 32'h7;
            feat_sub_i = (j == 1) ? 32'h1 : 32'h0;
            exp_f.push_back((j == 0) ? 32'h20 : 32'h0);
            @(posedge core_clk_i);
            #1;
            chk_f = 1'b1;
            @(posedge core_clk_i);
            #1;
            chk_f = 1'b0;
        end
        show(4'h3);
        load(4'h1, rnd());
        load(4'hb, rnd());
        issue(mk(5'h0b, 1'b0, 4'h1, 4'hb, 4'h0));
        rf[1][127:0] = rf[11][127:0];
        show(4'h1);
        c = mk(5'h0e, 1'b1, 4'h1, 4'h0, 4'h0);
        c.ldata = rnd();
        issue(c);
        rf[1][255:128] = c.ldata[255:128];
        issue(mk(5'h0d, 1'b1, 4'h1, 4'h0, 4'h0));
        show(4'h1);
        issue(mk(5'h0c, 1'b0, 4'h2, 4'h1, 4'h0));
        rf[2] = {128'h0, rf[1][127:0]};
        show(4'h2);
        issue(mk(5'h0c, 1'b1, 4'h3, 4'h1, 4'h0));
        rf[3] = rf[1];
        show(4'h3);
        for (int j = 0; j < 8; j++) begin
            load(4'h4, rnd());
            load(4'h5, rnd());
            c = mk(5'(1 + j % 4), 1'b1, 4'h6, (j % 2 == 1) ? 4'h5 : 4'h4, 4'h5);
            c.imm = 8'($urandom);
            for (int i = 0; i < 8; i++) a[32*i +: 32] = rf[5][32*rf[4][32*i +: 3] +: 32];
            if (j % 2 == 1) for (int i = 0; i < 4; i++) a[64*i +: 64] = rf[5][64*c.imm[2*i +: 2] +: 64];
            issue(c);
            rf[6] = a;
            show(4'h6);
        end
        for (int j = 0; j < 15; j++) begin
            b = rnd();
            for (int i = 0; i < 8; i++) begin
                if ($urandom % 4 != 0) b[32*i +: 32] = (j % 5 % 3 == 1 && i % 2 == 1) ? 0 : $urandom % 72;
            end
            load(4'h4, rnd());
            load(4'h5, b);
            w = 1'($urandom);
            issue(mk(5'(5 + j % 5), w, 4'h7, 4'h4, 4'h5));
            rf[7] = shf(5'(5 + j % 5), w, rf[4], b);
            show(4'h7);
        end
        for (int j = 0; j < 16; j++) begin
            et = 2'(j % 4);
            qx = 1'((j / 4) % 2);
            w = (j >= 8);
            for (int i = 0; i < 8; i++) begin
                x = int'($urandom % 512) - 256;
                if (!qx) a[32*i +: 32] = x;
                else if (i < 4) a[64*i +: 64] = 64'(x);
            end
            load(4'h8, a);
            load(4'h9, (j == 0) ? '0 : rnd());
            load(4'ha, rnd());
            c = mk(5'h0a, w, 4'ha, 4'h8, 4'h9);
            c.etype = vpsg_pkg::vpsg_etype_t'(et);
            c.qidx = qx;
            c.base = {$urandom, $urandom};
            c.scale_log2 = 2'($urandom);
            lat = 8'($urandom % 4);
            n0 = req_cnt;
            issue(c);
            rf[10] = gat(rf[10], a, rf[9], c.base, c.scale_log2, et, qx, w, nq);
            cmp_word("memory requests", 32'(nq), req_cnt - n0);
            show(4'ha);
        end
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
